// ### bench/adcctl_analog_model.sv
// analog sampling stage and comparator model facing the converter timing control.
// assumes level_i is the analog input in lsb units, possibly outside 0..1023.
`timescale 1ns/1ps
module adcctl_analog_model (
  input wire logic clk_sys_i,
  input wire logic sample_i,
  input wire logic [9:0] trial_code_i,
  input wire logic signed [31:0] level_i,
  output logic compare_high_o,
  output logic below_ground_o,
  output logic above_reference_o
);
  int held = 0;
  logic toggle = 1'b0;
  always @(posedge clk_sys_i) begin
    toggle <= ~toggle;
    if (sample_i) begin
      held <= level_i;
    end
  end
  // flags only mean something while sampling; elsewhere they wander
  assign below_ground_o = sample_i ? (level_i < 0) : toggle;
  assign above_reference_o = sample_i ? (level_i > 1023) : ~toggle;
  assign compare_high_o = held >= int'(trial_code_i);
endmodule : adcctl_analog_model

// ### bench/tb_adcctl_top.sv
// self-checking bench for the converter timing control: conversion length,
// sample window, result, saturation, completion pulse and calibration.
// assumes a 100 MHz cpu clock and the analog model on the comparator side.
`timescale 1ns/1ps
module tb_adcctl_top;
  import adcctl_pkg::*;
  logic clk_sys_i = 1'b0;
  logic reset_i = 1'b1;
  logic [15:0] cw = 16'h4000;
  logic start = 1'b0;
  int level = 0;
  logic cmp, blw, abv, smp, hld, bsy, cal, done;
  logic [9:0] trial, res;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  int cal_cyc = 0;
  int lv[8] = '{-5, 0, 1, 511, 512, 1022, 1023, 1500};

  always #5 clk_sys_i = ~clk_sys_i;

  adcctl_top DUT (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .converter_control_word_i(cw),
    .start_i(start), .compare_high_i(cmp), .below_ground_i(blw), .above_reference_i(abv),
    .sample_o(smp), .hold_o(hld), .trial_code_o(trial), .busy_o(bsy), .calibrating_o(cal),
    .result_o(res), .done_o(done));

  adcctl_analog_model model (.clk_sys_i(clk_sys_i), .sample_i(smp), .trial_code_i(trial),
    .level_i(level), .compare_high_o(cmp), .below_ground_o(blw), .above_reference_o(abv));

  function automatic int bc_len(input logic [1:0] c);
    return c == 2'b00 ? 4 : c == 2'b01 ? 2 : c == 2'b10 ? 16 : 8;
  endfunction : bc_len

  function automatic int smp_len(input logic [1:0] c);
    return 8 << c;
  endfunction : smp_len

  function automatic logic [9:0] clamp(input int v);
    return v < 0 ? 10'h000 : v > 1023 ? 10'h3FF : v[9:0];
  endfunction : clamp

  task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : check

  task automatic print_verdict;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : print_verdict

  // input moves after sampling ends, so only the held value may count
  task automatic convert(input logic [1:0] dc, input logic [1:0] sc, input int lvl, input int late);
    int nb, ns, nh, k;
    nb = 0;
    ns = 0;
    nh = 0;
    @(posedge clk_sys_i);
    cw <= {dc, sc, 12'($urandom)};
    start <= 1'b1;
    level <= lvl;
    @(posedge clk_sys_i);
    start <= 1'b0;
    for (k = 0; k < 4000 && done !== 1'b1; k++) begin
      @(negedge clk_sys_i);
      if (bsy === 1'b1) nb++;
      if (hld === smp) nh++;
      if (smp === 1'b1) ns++;
      else if (ns > 0) level = late;
    end
    check(16'(nb), 16'(bc_len(dc) * (smp_len(sc) + 40) + 2), "busy cycles");
    check(16'(ns), 16'(bc_len(dc) * smp_len(sc)), "sample cycles");
    check(res, clamp(lvl), "result");
    check(16'(nh), 16'h0000, "hold against sample");
    @(negedge clk_sys_i);
    check(done, 1'b0, "done width");
  endtask : convert

  always @(negedge clk_sys_i) begin
    if (!reset_i && cal === 1'b1) cal_cyc++;
  end

  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 60000) begin
      error_cnt++;
      print_verdict();
    end
  end

  initial begin
    int k;
    void'($urandom(50));
    repeat (16) @(posedge clk_sys_i);
    check({hld, cal, bsy, done}, 4'b1100, "reset outputs");
    reset_i <= 1'b0;
    convert(2'b01, 2'b00, 300, 900);
    for (k = 0; k < 20000 && cal === 1'b1; k++) @(negedge clk_sys_i);
    // conversion time stretches calibration; a few cycles of start slack allowed
    check(cal_cyc >= 3328 * 2 + 98 && cal_cyc <= 3328 * 2 + 106, 1'b1, "calibration");
    // sweep reaches every divider code for timing and result; at 100 MHz just code 10 is a legal basic clock
    for (k = 0; k < 16; k++) begin
      convert(k[3:2], k[1:0], lv[k % 8], int'($urandom_range(1023)));
    end
    for (k = 0; k < 12; k++) begin
      convert(2'b10, 2'($urandom), int'($urandom_range(1200)) - 100, int'($urandom_range(1023)));
    end
    print_verdict();
  end
endmodule : tb_adcctl_top

// ### logic/adcctl_pkg.sv
// package for the converter timing control: control word fields, divider and
// sample tables, fixed conversion and calibration counts.
// assumes one cpu clock domain; no software-visible registers.
package adcctl_pkg;
  localparam int unsigned ADCCTL_CW_WIDTH = 16;
  localparam int unsigned ADCCTL_DIV_MSB = 15;
  localparam int unsigned ADCCTL_DIV_LSB = 14;
  localparam int unsigned ADCCTL_SMP_MSB = 13;
  localparam int unsigned ADCCTL_SMP_LSB = 12;
  localparam int unsigned ADCCTL_RES_WIDTH = 10;
  localparam logic [9:0] ADCCTL_RES_ZERO = 10'h000;
  localparam logic [9:0] ADCCTL_RES_FULL = 10'h3FF;
  // conversion body and tail, in basic clocks and cpu clocks
  localparam logic [6:0] ADCCTL_CONV_BC = 7'h28;
  localparam logic [1:0] ADCCTL_TAIL_CPU = 2'h2;
  localparam logic [11:0] ADCCTL_CAL_BC = 12'hD00;
  localparam int unsigned ADCCTL_BIT_BC = 4;
  localparam logic [3:0] ADCCTL_DIV_MAX = 4'hF;
  typedef enum logic [2:0] {
    ADCCTL_IDLE = 3'b000,
    ADCCTL_SAMPLE = 3'b001,
    ADCCTL_DETERMINE = 3'b010,
    ADCCTL_TAIL = 3'b011,
    ADCCTL_WRITE = 3'b100
  } adcctl_state_e;

  // divider code to cpu clocks per basic clock, minus one
  function automatic logic [3:0] adcctl_div_last(input logic [1:0] code);
    case (code)
      2'b00: adcctl_div_last = 4'h3;
      2'b01: adcctl_div_last = 4'h1;
      2'b10: adcctl_div_last = 4'hF;
      default: adcctl_div_last = 4'h7;
    endcase
  endfunction : adcctl_div_last

  // sample code to basic clocks of sampling
  function automatic logic [6:0] adcctl_smp_len(input logic [1:0] code);
    case (code)
      2'b00: adcctl_smp_len = 7'h08;
      2'b01: adcctl_smp_len = 7'h10;
      2'b10: adcctl_smp_len = 7'h20;
      default: adcctl_smp_len = 7'h40;
    endcase
  endfunction : adcctl_smp_len
endpackage : adcctl_pkg

// ### logic/adcctl_prescaler.sv
// basic clock prescaler: one-cycle tick every N cpu clocks, N from the divider code.
// assumes restart re-aligns the count at the start of a conversion.
`timescale 1ns/1ps
module adcctl_prescaler
  import adcctl_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_i,
  adcctl_tick_if.gen tick_port
);
  logic [3:0] count;
  logic [3:0] next_count;

  always_comb begin
    next_count = count + 4'h1;
    if (tick_port.restart || count >= adcctl_div_last(tick_port.div_code)) begin
      next_count = 4'h0;
    end
  end

  assign tick_port.tick = (count >= adcctl_div_last(tick_port.div_code)) && !tick_port.restart;

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      count <= 4'h0;
    end else begin
      count <= next_count;
    end
  end

  chk_tick_period: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    tick_port.tick && tick_port.div_code == 2'b00 |=> !tick_port.tick [*3])
    else $error("basic clock tick spacing wrong");
endmodule : adcctl_prescaler

// ### logic/adcctl_tick_if.sv
// interface carrying the basic-clock tick from the prescaler to the sequencer.
// assumes both ends share clk_sys_i.
`timescale 1ns/1ps
interface adcctl_tick_if;
  logic [1:0] div_code;
  logic restart;
  logic tick;
  modport gen (input div_code, input restart, output tick);
  modport use_end (output div_code, output restart, input tick);
endinterface : adcctl_tick_if

// ### logic/adcctl_top.sv
// conversion timing control: basic clock, sample window, fixed-length
// conversion, post-reset calibration and result saturation.
// assumes the analog core supplies compare results and range flags per step.
`timescale 1ns/1ps
// Operation
// - basic clock is cpu clock divided by 4, 2, 16 or 8 per bits 15:14.
// - sampling lasts 8, 16, 32 or 64 basic clocks per bits 13:12.
// - conversion lasts exactly sample time plus 40 basic clocks plus 2 cpu clocks.
// - conversion runs sampling, then bit determination, then result write.
// - after reset calibration runs for 3328 basic clocks.
// - conversions are accepted during calibration and extend its duration.
// - result saturates to zero below ground and full scale above reference.
// - sampled input is held once sampling ends.
module adcctl_top
  import adcctl_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic reset_i,
  input wire logic [15:0] converter_control_word_i,
  input wire logic start_i,
  input wire logic compare_high_i,
  input wire logic below_ground_i,
  input wire logic above_reference_i,
  output logic sample_o,
  output logic hold_o,
  output logic [9:0] trial_code_o,
  output logic busy_o,
  output logic calibrating_o,
  output logic [9:0] result_o,
  output logic done_o
);
  adcctl_tick_if tick_bus ();

  adcctl_state_e state;
  adcctl_state_e next_state;
  logic [6:0] bc_count;
  logic [6:0] next_bc_count;
  logic [1:0] tail_count;
  logic [1:0] next_tail_count;
  logic [1:0] div_code;
  logic [1:0] next_div_code;
  logic [6:0] smp_len;
  logic [6:0] next_smp_len;
  logic [9:0] sar;
  logic [9:0] next_sar;
  logic [3:0] bit_idx;
  logic [3:0] next_bit_idx;
  logic under;
  logic next_under;
  logic over;
  logic next_over;
  logic [9:0] result;
  logic [9:0] next_result;
  logic done;
  logic next_done;
  logic [11:0] cal_count;
  logic [11:0] next_cal_count;
  logic cal_active;
  logic next_cal_active;

  assign tick_bus.div_code = div_code;
  assign tick_bus.restart = (state == ADCCTL_IDLE);

  adcctl_prescaler u_prescaler (
    .clk_sys_i(clk_sys_i),
    .reset_i(reset_i),
    .tick_port(tick_bus)
  );

  // sequencer
  always_comb begin
    next_state = state;
    next_bc_count = bc_count;
    next_tail_count = tail_count;
    next_div_code = div_code;
    next_smp_len = smp_len;
    next_sar = sar;
    next_bit_idx = bit_idx;
    next_under = under;
    next_over = over;
    next_result = result;
    next_done = 1'b0;
    case (state)
      ADCCTL_IDLE: begin
        if (start_i) begin
          // settings are latched so a mid-conversion write cannot stretch it
          next_div_code = converter_control_word_i[ADCCTL_DIV_MSB:ADCCTL_DIV_LSB];
          next_smp_len = adcctl_smp_len(converter_control_word_i[ADCCTL_SMP_MSB:ADCCTL_SMP_LSB]);
          next_bc_count = 7'h00;
          next_under = 1'b0;
          next_over = 1'b0;
          next_state = ADCCTL_SAMPLE;
        end
      end
      ADCCTL_SAMPLE: begin
        if (tick_bus.tick) begin
          next_under = below_ground_i;
          next_over = above_reference_i;
          next_bc_count = bc_count + 7'h01;
          if (bc_count + 7'h01 == smp_len) begin
            next_bc_count = 7'h00;
            next_sar = 10'h200;
            next_bit_idx = 4'h9;
            next_state = ADCCTL_DETERMINE;
          end
        end
      end
      ADCCTL_DETERMINE: begin
        if (tick_bus.tick) begin
          next_bc_count = bc_count + 7'h01;
          // one result bit resolved every four basic clocks
          if (bc_count[1:0] == 2'(ADCCTL_BIT_BC - 1)) begin
            if (!compare_high_i) begin
              next_sar[bit_idx] = 1'b0;
            end
            if (bit_idx != 4'h0) begin
              next_sar[bit_idx - 4'h1] = 1'b1;
              next_bit_idx = bit_idx - 4'h1;
            end
          end
          if (bc_count + 7'h01 == ADCCTL_CONV_BC) begin
            next_tail_count = 2'h0;
            next_state = ADCCTL_TAIL;
          end
        end
      end
      ADCCTL_TAIL: begin
        next_tail_count = tail_count + 2'h1;
        if (tail_count + 2'h1 == ADCCTL_TAIL_CPU - 2'h1) begin
          next_state = ADCCTL_WRITE;
        end
      end
      ADCCTL_WRITE: begin
        if (under) begin
          next_result = ADCCTL_RES_ZERO;
        end else if (over) begin
          next_result = ADCCTL_RES_FULL;
        end else begin
          next_result = sar;
        end
        next_done = 1'b1;
        next_state = ADCCTL_IDLE;
      end
      default: begin
        next_state = ADCCTL_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      state <= ADCCTL_IDLE;
      bc_count <= 7'h00;
      tail_count <= 2'h0;
      div_code <= 2'b00;
      smp_len <= 7'h08;
      sar <= 10'h000;
      bit_idx <= 4'h0;
      under <= 1'b0;
      over <= 1'b0;
      result <= 10'h000;
      done <= 1'b0;
    end else begin
      state <= next_state;
      bc_count <= next_bc_count;
      tail_count <= next_tail_count;
      div_code <= next_div_code;
      smp_len <= next_smp_len;
      sar <= next_sar;
      bit_idx <= next_bit_idx;
      under <= next_under;
      over <= next_over;
      result <= next_result;
      done <= next_done;
    end
  end

  // calibration counter: own basic clock from the current divider code, paused
  // while a conversion runs so conversion time adds to the total
  logic [3:0] cal_div;
  logic [3:0] next_cal_div;
  always_comb begin
    next_cal_active = cal_active;
    next_cal_count = cal_count;
    next_cal_div = cal_div;
    if (cal_active && state == ADCCTL_IDLE && !start_i) begin
      next_cal_div = cal_div + 4'h1;
      if (cal_div >= adcctl_div_last(converter_control_word_i[ADCCTL_DIV_MSB:ADCCTL_DIV_LSB])) begin
        next_cal_div = 4'h0;
        next_cal_count = cal_count + 12'h001;
        if (cal_count + 12'h001 == ADCCTL_CAL_BC) begin
          next_cal_active = 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge reset_i) begin
    if (reset_i) begin
      cal_active <= 1'b1;
      cal_count <= 12'h000;
      cal_div <= 4'h0;
    end else begin
      cal_active <= next_cal_active;
      cal_count <= next_cal_count;
      cal_div <= next_cal_div;
    end
  end

  assign sample_o = (state == ADCCTL_SAMPLE);
  assign hold_o = (state != ADCCTL_SAMPLE);
  assign trial_code_o = sar;
  assign busy_o = (state != ADCCTL_IDLE);
  assign calibrating_o = cal_active;
  assign result_o = result;
  assign done_o = done;

  chk_done_single: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    done_o |=> !done_o)
    else $error("completion pulse longer than one cycle");

  chk_done_after_write: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    $rose(done_o) |-> $past(state) == ADCCTL_WRITE)
    else $error("completion without result write");

  chk_saturate_low: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    state == ADCCTL_WRITE && under |=> result_o == ADCCTL_RES_ZERO)
    else $error("low saturation missing");

  chk_saturate_high: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    state == ADCCTL_WRITE && !under && over |=> result_o == ADCCTL_RES_FULL)
    else $error("high saturation missing");

  chk_tail_length: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    state == ADCCTL_DETERMINE ##1 state == ADCCTL_TAIL |-> ##1 state == ADCCTL_WRITE ##1 state == ADCCTL_IDLE)
    else $error("cpu tail not two cycles");

  chk_hold_after: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    $fell(sample_o) |-> hold_o && state == ADCCTL_DETERMINE)
    else $error("input not held after sampling");

  chk_cal_pause: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    busy_o && calibrating_o |=> $stable(cal_count))
    else $error("calibration advanced during conversion");

  chk_sample_count: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    state == ADCCTL_SAMPLE |-> bc_count < smp_len)
    else $error("sample window overran");

  chk_cal_end: assert property (@(posedge clk_sys_i) disable iff (reset_i)
    $fell(calibrating_o) |-> cal_count == ADCCTL_CAL_BC)
    else $error("calibration ended at wrong count");
endmodule : adcctl_top
